// File: pkg/fbc_defines.vh
/*
 * constants for the feeder bay control block: register offsets,
 * field positions, reset values, preset schemes and timing counts.
 * assumes inclusion by bare name from the design files.
 */
`ifndef FBC_DEFINES_VH
`define FBC_DEFINES_VH

// ======================================
// bus shape
`define FBC_AW 8
`define FBC_DW 16

// ======================================
// register offsets
`define FBC_REG_CTRL 8'h00
`define FBC_REG_POL 8'h04
`define FBC_REG_OPEN_ASG 8'h08
`define FBC_REG_CLOSE_ASG 8'h0C
`define FBC_REG_SIG1_ASG 8'h10
`define FBC_REG_SIG2_ASG 8'h14
`define FBC_REG_SIG3_ASG 8'h18
`define FBC_REG_LED_MAP 8'h1C
`define FBC_REG_ILK_OM 8'h20
`define FBC_REG_ILK_OV 8'h24
`define FBC_REG_ILK_CM 8'h28
`define FBC_REG_ILK_CV 8'h2C
`define FBC_REG_STATE 8'h30
`define FBC_REG_CMD 8'h34
`define FBC_REG_IRQ_STAT 8'h38
`define FBC_REG_IRQ_MASK 8'h3C
`define FBC_REG_ENERGY_LO 8'h40
`define FBC_REG_ENERGY_HI 8'h44
`define FBC_REG_P_MW 8'h48
`define FBC_REG_Q_MVAR 8'h4C
`define FBC_REG_SCALE_P 8'h50
`define FBC_REG_SCALE_Q 8'h54

// ======================================
// field positions
`define FBC_CTRL_COND 0
`define FBC_CTRL_ESRC 1
`define FBC_CTRL_SCH_LO 2
`define FBC_CTRL_SCH_HI 3
`define FBC_CTRL_BLK8 4
`define FBC_CTRL_BLK9 5
`define FBC_CMD_OPEN 0
`define FBC_CMD_CLOSE 1
`define FBC_IRQ_OPEN 0
`define FBC_IRQ_CLOSE 1
`define FBC_IRQ_DROP 2
`define FBC_IRQ_TRIP 3
`define FBC_IRQ_CHAN 4
`define FBC_IRQ_W 5
`define FBC_SCALE_SH 8

// ======================================
// reset values
`define FBC_RST_CTRL 16'h0000
`define FBC_RST_POL 16'h0000
`define FBC_RST_OPEN_ASG 16'h0000
`define FBC_RST_CLOSE_ASG 16'h0000
`define FBC_RST_SIG1_ASG 16'h0040
`define FBC_RST_SIG2_ASG 16'h0000
`define FBC_RST_SIG3_ASG 16'h0280
`define FBC_RST_LED_MAP 16'h0210
`define FBC_RST_ILK 16'h0000
`define FBC_RST_SCALE 16'h0100

// ======================================
// preset schemes: open mask/value, close mask/value
`define FBC_PS1_CM 16'h0028
`define FBC_PS1_CV 16'h0028
`define FBC_PS2_CM 16'h0008
`define FBC_PS2_CV 16'h0008
`define FBC_PS3_OM 16'h0008
`define FBC_PS3_OV 16'h0008
`define FBC_PS3_CM 16'h0038
`define FBC_PS3_CV 16'h0018

// ======================================
// timing
`define FBC_CLK_MHZ 100
`define FBC_PULSE_MS 100
`define FBC_EINT_MS 1000
`define FBC_PULSE_CYC (`FBC_PULSE_MS * 1000 * `FBC_CLK_MHZ)
`define FBC_EINT_CYC (`FBC_EINT_MS * 1000 * `FBC_CLK_MHZ)

`endif

// File: hdl/fbc_pulse.v
/*
 * fixed-length command pulse generator, not retriggerable.
 * assumes start is a one-cycle request qualified by the caller.
 */
`timescale 1ns/10ps
`include "fbc_defines.vh"

module fbc_pulse #(
    parameter CW = 24,
    parameter [CW-1:0] LEN = `FBC_PULSE_CYC
) (
    // clock and reset
    input wire sys_clk,
    input wire sys_rst,
    // request
    input wire start,
    // pulse
    output wire busy,
    output wire pulse
);

    reg [CW-1:0] cnt_r;

    // ======================================
    // down counter, ignores start while running
    always @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_r <= {CW{1'b0}};
        end else if (cnt_r != {CW{1'b0}}) begin
            cnt_r <= cnt_r - {{(CW-1){1'b0}}, 1'b1};
        end else if (start) begin
            cnt_r <= LEN;
        end
    end

    assign busy = (cnt_r != {CW{1'b0}});
    assign pulse = busy;

endmodule // fbc_pulse

// File: hdl/fbc_energy.v
/*
 * active energy accumulator: power integration or meter pulse count.
 * assumes pwr is a signed scaled power word, meter a clean level.
 */
`timescale 1ns/10ps
`include "fbc_defines.vh"

module fbc_energy #(
    parameter CW = 27,
    parameter [CW-1:0] EINT = `FBC_EINT_CYC
) (
    // clock and reset
    input wire sys_clk,
    input wire sys_rst,
    // control
    input wire use_meter,
    input wire clr,
    // sources
    input wire meter,
    input wire [15:0] pwr,
    // result
    output reg [31:0] energy_r
);

    reg [CW-1:0] tick_r;
    reg meter_q_r;
    wire tick = (tick_r == EINT - {{(CW-1){1'b0}}, 1'b1});
    wire meter_rise = meter & ~meter_q_r;

    // ======================================
    // integration period counter and meter edge
    always @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            tick_r <= {CW{1'b0}};
            meter_q_r <= 1'b0;
        end else begin
            tick_r <= tick ? {CW{1'b0}} : tick_r + {{(CW-1){1'b0}}, 1'b1};
            meter_q_r <= meter;
        end
    end

    // ======================================
    // accumulate by one of two sources
    always @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            energy_r <= 32'h00000000;
        end else if (clr) begin
            energy_r <= 32'h00000000;
        end else if (use_meter) begin
            if (meter_rise) begin
                energy_r <= energy_r + 32'h00000001;
            end
        end else if (tick) begin
            energy_r <= energy_r + {{16{pwr[15]}}, pwr};
        end
    end

endmodule // fbc_energy

// File: hdl/fbc_top.v
/*
 * feeder bay control: status inputs, indicators, interlocked
 * open/close commands, signalling outputs, power and energy.
 * assumes all inputs synchronous to sys_clk and a simple
 * register port with read data one cycle after the strobe.
 */
// The placing of the registers and the plain strobed port were chosen for this implementation.
`timescale 1ns/10ps
`include "fbc_defines.vh"

// Overview of operation
// - each object status comes from an open input and a closed input
// - a 4x4 lamp matrix shows up to three object positions as mapped
// - only object one is controlled, solely via the open and close outputs
// - every single channel has a polarity bit choosing active high or low
// - each external channel lights its own red lamp while active
// - an assigned channel becoming active issues one command pulse
// - signalling outputs follow their assigned channels while active
// - each command is checked against interlocking, then pulsed or dropped
// - interlocking looks at object positions and single channel states
// - protection trips drive the open output bypassing interlocking
// - preset interlocking schemes come with matching preset lamp layouts
// - conditional mode drives outputs from interlocking and channel states
// - energy is integrated from power or counted from channel 7 pulses
// - current-loop readings are scaled to megawatts and megavars
// - internal channels carry protection start and trip signals
// - open and close commands arrive from the station bus or push-buttons
// - channels 8 and 9 can block protection trips as control inputs
module fbc_top #(
    parameter PCW = 24,
    parameter [PCW-1:0] PULSE_CYC = `FBC_PULSE_CYC,
    parameter ECW = 27,
    parameter [ECW-1:0] EINT_CYC = `FBC_EINT_CYC
) (
    // clock and reset
    input wire sys_clk,
    input wire sys_rst,
    // register port
    input wire [`FBC_AW-1:0] reg_addr,
    input wire [`FBC_DW-1:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [`FBC_DW-1:0] reg_rdata_r,
    // object status pairs
    input wire [2:0] obj_open_in,
    input wire [2:0] obj_closed_in,
    // single channels 4..9 and protection 10..13
    input wire [5:0] ext_in,
    input wire [3:0] prot_in,
    // local push-buttons
    input wire pb_open,
    input wire pb_close,
    // current-loop transducer words
    input wire [15:0] ma_p,
    input wire [15:0] ma_q,
    // switchgear outputs
    output reg open_out_r,
    output reg close_out_r,
    output reg [2:0] sig_out_r,
    // panel lamps
    output reg [15:0] led_mtx_r,
    output reg [5:0] led_red_r,
    // interrupt
    output wire irq
);

    // ======================================
    // functions
    function ilk_ok;
        input [15:0] cond;
        input [15:0] msk;
        input [15:0] val;
        begin
            ilk_ok = (((cond ^ val) & msk) == 16'h0000);
        end
    endfunction

    function [15:0] scale;
        input [15:0] raw;
        input [15:0] gain;
        reg signed [32:0] prod;
        begin
            prod = $signed(raw) * $signed({1'b0, gain});
            scale = prod[`FBC_SCALE_SH+15:`FBC_SCALE_SH];
        end
    endfunction

    // ======================================
    // registers
    reg [15:0] ctrl_r, pol_r, open_asg_r, close_asg_r;
    reg [15:0] sig1_r, sig2_r, sig3_r, led_map_r;
    reg [15:0] om_r, ov_r, cm_r, cv_r, scale_p_r, scale_q_r;
    reg [15:0] p_mw_r, q_mvar_r;
    reg [`FBC_IRQ_W-1:0] irq_stat_r, irq_mask_r;
    reg [`FBC_IRQ_W-1:0] irq_stat_nxt;
    reg [9:0] act_q_r;
    reg trip_q_r;
    reg [15:0] om, ov, cm, cv, lmap;
    reg [15:0] led_nxt;
    reg [15:0] rdata_nxt;
    integer i;
    wire [31:0] energy;

    wire wr_hit_cmd = reg_wr & (reg_addr == `FBC_REG_CMD);
    wire rd_irq = reg_rd & (reg_addr == `FBC_REG_IRQ_STAT);
    wire [1:0] sch = ctrl_r[`FBC_CTRL_SCH_HI:`FBC_CTRL_SCH_LO];
    wire cond_mode = ctrl_r[`FBC_CTRL_COND];

    // ======================================
    // channel states and conditions
    wire [9:0] raw = {prot_in, ext_in};
    wire [9:0] act = raw ^ pol_r[9:0];
    wire [9:0] rise = act & ~act_q_r;
    wire [5:0] pos = {obj_closed_in[2], obj_open_in[2], obj_closed_in[1],
                      obj_open_in[1], obj_closed_in[0], obj_open_in[0]};
    wire [15:0] cond = {act, pos};

    // internal channels 10..13: start1, trip1, start2, trip2
    wire blocked = (ctrl_r[`FBC_CTRL_BLK8] & act[4]) |
                   (ctrl_r[`FBC_CTRL_BLK9] & act[5]);
    wire trip = (act[7] | act[9]) & ~blocked;

    // preset scheme selection, zero means the user program
    always @* begin
        om = om_r;
        ov = ov_r;
        cm = cm_r;
        cv = cv_r;
        lmap = led_map_r;
        case (sch)
            2'd1: begin
                om = 16'h0000; ov = 16'h0000;
                cm = `FBC_PS1_CM; cv = `FBC_PS1_CV;
                lmap = `FBC_RST_LED_MAP;
            end
            2'd2: begin
                om = 16'h0000; ov = 16'h0000;
                cm = `FBC_PS2_CM; cv = `FBC_PS2_CV;
                lmap = 16'h0510;
            end
            2'd3: begin
                om = `FBC_PS3_OM; ov = `FBC_PS3_OV;
                cm = `FBC_PS3_CM; cv = `FBC_PS3_CV;
                lmap = 16'h0950;
            end
            default: begin
                om = om_r;
            end
        endcase
    end

    wire ok_open = ilk_ok(cond, om, ov);
    wire ok_close = ilk_ok(cond, cm, cv);

    // ======================================
    // command sources and interlock decision
    wire cmd_open = pb_open | (wr_hit_cmd & reg_wdata[`FBC_CMD_OPEN]) |
                    (|(rise & open_asg_r[9:0]));
    wire cmd_close = pb_close | (wr_hit_cmd & reg_wdata[`FBC_CMD_CLOSE]) |
                     (|(rise & close_asg_r[9:0]));
    wire open_busy, close_busy, open_pulse, close_pulse;
    wire open_go = cmd_open & ok_open & ~open_busy;
    wire close_go = cmd_close & ~cmd_open & ok_close & ~close_busy &
                    ~open_busy & ~trip;
    wire drop = (cmd_open & ~open_go) | (cmd_close & ~close_go);

    fbc_pulse #(.CW(PCW), .LEN(PULSE_CYC)) u_open_pulse (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .start(open_go),
        .busy(open_busy),
        .pulse(open_pulse)
    );

    fbc_pulse #(.CW(PCW), .LEN(PULSE_CYC)) u_close_pulse (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .start(close_go),
        .busy(close_busy),
        .pulse(close_pulse)
    );

    // conditional levels from interlocking and channel states
    wire cond_open = cond_mode & ok_open & (|(act & open_asg_r[9:0]));
    wire cond_close = cond_mode & ok_close & (|(act & close_asg_r[9:0]));

    // ======================================
    // switchgear outputs for object one
    always @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            open_out_r <= 1'b0;
            close_out_r <= 1'b0;
            sig_out_r <= 3'b000;
            act_q_r <= 10'h000;
            trip_q_r <= 1'b0;
        end else begin
            open_out_r <= open_pulse | cond_open | trip;
            close_out_r <= (close_pulse | cond_close) & ~trip;
            sig_out_r[0] <= |(act & sig1_r[9:0]);
            sig_out_r[1] <= |(act & sig2_r[9:0]);
            sig_out_r[2] <= |(act & sig3_r[9:0]);
            act_q_r <= act;
            trip_q_r <= trip;
        end
    end

    // ======================================
    // lamps: matrix lit where a mapped object is closed
    always @* begin
        led_nxt = 16'h0000;
        for (i = 0; i < 3; i = i + 1) begin
            if (obj_closed_in[i] & ~obj_open_in[i]) begin
                led_nxt[lmap[4*i +: 4]] = 1'b1;
            end
        end
    end

    always @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            led_mtx_r <= 16'h0000;
            led_red_r <= 6'h00;
        end else begin
            led_mtx_r <= led_nxt;
            led_red_r <= act[5:0];
        end
    end

    // ======================================
    // power scaling and energy
    always @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            p_mw_r <= 16'h0000;
            q_mvar_r <= 16'h0000;
        end else begin
            p_mw_r <= scale(ma_p, scale_p_r);
            q_mvar_r <= scale(ma_q, scale_q_r);
        end
    end

    fbc_energy #(.CW(ECW), .EINT(EINT_CYC)) u_energy (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .use_meter(ctrl_r[`FBC_CTRL_ESRC]),
        .clr(reg_wr & (reg_addr == `FBC_REG_ENERGY_LO)),
        .meter(act[3]),
        .pwr(p_mw_r),
        .energy_r(energy)
    );

    // ======================================
    // interrupt status, cleared by read, set wins
    always @* begin
        irq_stat_nxt = rd_irq ? {`FBC_IRQ_W{1'b0}} : irq_stat_r;
        if (open_go) irq_stat_nxt[`FBC_IRQ_OPEN] = 1'b1;
        if (close_go) irq_stat_nxt[`FBC_IRQ_CLOSE] = 1'b1;
        if (drop) irq_stat_nxt[`FBC_IRQ_DROP] = 1'b1;
        if (trip & ~trip_q_r) irq_stat_nxt[`FBC_IRQ_TRIP] = 1'b1;
        if (|rise[5:0]) irq_stat_nxt[`FBC_IRQ_CHAN] = 1'b1;
    end

    assign irq = |(irq_stat_r & irq_mask_r);

    // ======================================
    // register writes
    always @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl_r <= `FBC_RST_CTRL;
            pol_r <= `FBC_RST_POL;
            open_asg_r <= `FBC_RST_OPEN_ASG;
            close_asg_r <= `FBC_RST_CLOSE_ASG;
            sig1_r <= `FBC_RST_SIG1_ASG;
            sig2_r <= `FBC_RST_SIG2_ASG;
            sig3_r <= `FBC_RST_SIG3_ASG;
            led_map_r <= `FBC_RST_LED_MAP;
            om_r <= `FBC_RST_ILK;
            ov_r <= `FBC_RST_ILK;
            cm_r <= `FBC_RST_ILK;
            cv_r <= `FBC_RST_ILK;
            scale_p_r <= `FBC_RST_SCALE;
            scale_q_r <= `FBC_RST_SCALE;
            irq_mask_r <= {`FBC_IRQ_W{1'b0}};
            irq_stat_r <= {`FBC_IRQ_W{1'b0}};
        end else begin
            irq_stat_r <= irq_stat_nxt;
            if (reg_wr) begin
                case (reg_addr)
                    `FBC_REG_CTRL: ctrl_r <= {10'h000, reg_wdata[5:0]};
                    `FBC_REG_POL: pol_r <= {6'h00, reg_wdata[9:0]};
                    `FBC_REG_OPEN_ASG: open_asg_r <= {6'h00, reg_wdata[9:0]};
                    `FBC_REG_CLOSE_ASG: close_asg_r <= {6'h00, reg_wdata[9:0]};
                    `FBC_REG_SIG1_ASG: sig1_r <= {6'h00, reg_wdata[9:0]};
                    `FBC_REG_SIG2_ASG: sig2_r <= {6'h00, reg_wdata[9:0]};
                    `FBC_REG_SIG3_ASG: sig3_r <= {6'h00, reg_wdata[9:0]};
                    `FBC_REG_LED_MAP: led_map_r <= {4'h0, reg_wdata[11:0]};
                    `FBC_REG_ILK_OM: om_r <= reg_wdata;
                    `FBC_REG_ILK_OV: ov_r <= reg_wdata;
                    `FBC_REG_ILK_CM: cm_r <= reg_wdata;
                    `FBC_REG_ILK_CV: cv_r <= reg_wdata;
                    `FBC_REG_IRQ_MASK: irq_mask_r <= reg_wdata[`FBC_IRQ_W-1:0];
                    `FBC_REG_SCALE_P: scale_p_r <= reg_wdata;
                    `FBC_REG_SCALE_Q: scale_q_r <= reg_wdata;
                    default: ;
                endcase
            end
        end
    end

    // ======================================
    // register reads, unmapped reads as zero
    always @* begin
        case (reg_addr)
            `FBC_REG_CTRL: rdata_nxt = ctrl_r;
            `FBC_REG_POL: rdata_nxt = pol_r;
            `FBC_REG_OPEN_ASG: rdata_nxt = open_asg_r;
            `FBC_REG_CLOSE_ASG: rdata_nxt = close_asg_r;
            `FBC_REG_SIG1_ASG: rdata_nxt = sig1_r;
            `FBC_REG_SIG2_ASG: rdata_nxt = sig2_r;
            `FBC_REG_SIG3_ASG: rdata_nxt = sig3_r;
            `FBC_REG_LED_MAP: rdata_nxt = led_map_r;
            `FBC_REG_ILK_OM: rdata_nxt = om_r;
            `FBC_REG_ILK_OV: rdata_nxt = ov_r;
            `FBC_REG_ILK_CM: rdata_nxt = cm_r;
            `FBC_REG_ILK_CV: rdata_nxt = cv_r;
            `FBC_REG_STATE: rdata_nxt = cond;
            `FBC_REG_IRQ_STAT: rdata_nxt = {11'h000, irq_stat_r};
            `FBC_REG_IRQ_MASK: rdata_nxt = {11'h000, irq_mask_r};
            `FBC_REG_ENERGY_LO: rdata_nxt = energy[15:0];
            `FBC_REG_ENERGY_HI: rdata_nxt = energy[31:16];
            `FBC_REG_P_MW: rdata_nxt = p_mw_r;
            `FBC_REG_Q_MVAR: rdata_nxt = q_mvar_r;
            `FBC_REG_SCALE_P: rdata_nxt = scale_p_r;
            `FBC_REG_SCALE_Q: rdata_nxt = scale_q_r;
            default: rdata_nxt = 16'h0000;
        endcase
    end

    // read data stands only in the cycle after the strobe
    always @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata_r <= 16'h0000;
        end else begin
            reg_rdata_r <= reg_rd ? rdata_nxt : 16'h0000;
        end
    end

endmodule // fbc_top

// File: verif/fbc_checker.sv
/* port checker for fbc_top: read port, pulses, lamps, output causes.
   assumes fbc_top runs with PULSE_CYC set to 8. */
`timescale 1ns/10ps
`include "fbc_defines.vh"
// ======================================
// checker
module fbc_checker (
    // clock and reset
    input wire sys_clk,
    input wire sys_rst,
    // register port
    input wire [`FBC_AW-1:0] reg_addr,
    input wire reg_wr,
    input wire reg_rd,
    input wire [`FBC_DW-1:0] reg_rdata_r,
    // field inputs
    input wire [2:0] obj_open_in,
    input wire [2:0] obj_closed_in,
    input wire [5:0] ext_in,
    input wire [3:0] prot_in,
    input wire pb_open,
    input wire pb_close,
    // outputs
    input wire open_out_r,
    input wire close_out_r,
    input wire [2:0] sig_out_r,
    input wire [5:0] led_red_r,
    input wire irq
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    // read data only in the cycle after a read
    a_rd_idle: assert property (!$past(reg_rd) |-> reg_rdata_r == 16'h0000)
        else $error("read data not zero when idle");
    a_unmapped_zero: assert property (reg_rd && reg_addr == 8'h02 |=> reg_rdata_r == 16'h0000)
        else $error("unmapped read not zero");
    a_cmd_wo: assert property (reg_rd && reg_addr == `FBC_REG_CMD |=> reg_rdata_r == 16'h0000)
        else $error("command register readable");
    a_rst_quiet: assert property ($fell(sys_rst) |-> !open_out_r && !close_out_r && sig_out_r == 3'h0 && !irq)
        else $error("outputs active out of reset");
    a_open_len: assert property ($past(pb_open, 2) && $rose(open_out_r) |-> open_out_r[*8] ##1 !open_out_r)
        else $error("open pulse length wrong");
    a_close_len: assert property ($past(pb_close, 2) && !$past(pb_open, 2) && $rose(close_out_r)
        |-> close_out_r[*8] ##1 !close_out_r) else $error("close pulse length wrong");
    a_red_follow: assert property ($changed(led_red_r) |-> $past(ext_in) != $past(ext_in, 2)
        || $past(reg_wr, 2) || $past(sys_rst, 2)) else $error("red lamp changed without cause");
    a_open_cause: assert property ($rose(open_out_r) |-> $past(pb_open) || $past(pb_open, 2)
        || $past(reg_wr) || $past(reg_wr, 2) || $past(sys_rst, 2) || $past(ext_in, 2) != $past(ext_in, 3)
        || $past({ext_in, prot_in, obj_open_in, obj_closed_in})
        != $past({ext_in, prot_in, obj_open_in, obj_closed_in}, 2)) else $error("open output rose without cause");
endmodule // fbc_checker

bind fbc_top fbc_checker u_chk (.*);

// File: verif/fbc_gear_model.sv
/* switchgear model: breaker (object 1) moved by open/close outputs,
   objects 2 and 3 held by the bench. assumes the sys_clk domain. */
`timescale 1ns/10ps
// ======================================
// switchgear contacts
module fbc_gear_model #(
    parameter TRAVEL = 3
) (
    // clock and reset
    input wire sys_clk,
    input wire sys_rst,
    // commands from the terminal
    input wire open_out_r,
    input wire close_out_r,
    // disconnectors, 1 = closed
    input wire [1:0] pos23,
    // status contacts
    output wire [2:0] obj_open_in,
    output wire [2:0] obj_closed_in
);
    reg cl_r;
    reg [3:0] tr_r;
    // breaker travel, no contact made while moving
    always @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cl_r <= 1'h1;
            tr_r <= 4'h0;
        end else if (tr_r != 4'h0) begin
            tr_r <= tr_r - 4'h1;
            if (tr_r == 4'h1)
                cl_r <= ~cl_r;
        end else if ((open_out_r && cl_r) || (close_out_r && !cl_r)) begin
            tr_r <= TRAVEL[3:0];
        end
    end
    // one open and one closed contact per object
    assign obj_open_in = {~pos23, (tr_r == 4'h0) & ~cl_r};
    assign obj_closed_in = {pos23, (tr_r == 4'h0) & cl_r};
endmodule // fbc_gear_model

// File: verif/fbc_top_tb.sv
/* self-checking bench for fbc_top with the switchgear model.
   assumes short counts: pulse 8 cycles, energy interval 16. */
`timescale 1ns/10ps
`include "fbc_defines.vh"
module fbc_top_tb;
    // ======================================
    // stimulus and wiring
    reg sys_clk = 0;
    reg sys_rst = 1;
    reg [7:0] reg_addr = 0;
    reg [15:0] reg_wdata = 0;
    reg reg_wr = 0, reg_rd = 0, pb_open = 0, pb_close = 0;
    reg [5:0] ext_in = 0;
    reg [3:0] prot_in = 0;
    reg [1:0] pos23 = 0;
    reg [15:0] ma_p = 16'h0180, ma_q = 16'hFF00;
    wire [15:0] reg_rdata_r, led_mtx_r;
    wire [2:0] obj_open_in, obj_closed_in, sig_out_r;
    wire [5:0] led_red_r;
    wire open_out_r, close_out_r, irq;
    int err_total = 0, check_count = 0, cyc = 0, no, nc;
    always #5 sys_clk = ~sys_clk;
    fbc_top #(.PULSE_CYC(24'd8), .EINT_CYC(27'd16)) u_dut (.*);
    fbc_gear_model u_gear (.*);
    // ======================================
    // helpers
    task chk(input string n, input logic [15:0] s, input logic [15:0] e);
        check_count++;
        if (s !== e) begin
            err_total++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask
    task tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task look(input int n);
        tick(n);
        #1;
    endtask
    task wr(input logic [7:0] a, input logic [15:0] d);
        tick(1);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1;
        tick(1);
        reg_wr <= 0;
    endtask
    task rd(input logic [7:0] a, output logic [15:0] d);
        tick(1);
        reg_addr <= a;
        reg_rd <= 1;
        tick(1);
        reg_rd <= 0;
        #1;
        d = reg_rdata_r;
    endtask
    task rdchk(input string n, input logic [7:0] a, input logic [15:0] e);
        logic [15:0] d;
        rd(a, d);
        chk(n, d, e);
    endtask
    // one command, count output cycles
    task run(input logic po, pc, input logic [1:0] cmd, input logic [5:0] ext, input int hold);
        tick(1);
        pb_open <= po;
        pb_close <= pc;
        ext_in <= ext;
        reg_addr <= `FBC_REG_CMD;
        reg_wdata <= {14'h0, cmd};
        reg_wr <= |cmd;
        no = 0;
        nc = 0;
        for (int i = 0; i < 14; i++) begin
            tick(1);
            reg_wr <= 0;
            if (i == hold - 1) begin
                pb_open <= 0;
                pb_close <= 0;
            end
            #1;
            no += open_out_r;
            nc += close_out_r;
        end
    endtask
    // ======================================
    // scenarios
    task t_regs;
        chk("irq at reset", irq, 16'h0000);
        rdchk("ctrl", `FBC_REG_CTRL, `FBC_RST_CTRL);
        rdchk("sig1 asg", `FBC_REG_SIG1_ASG, `FBC_RST_SIG1_ASG);
        rdchk("sig3 asg", `FBC_REG_SIG3_ASG, `FBC_RST_SIG3_ASG);
        rdchk("led map", `FBC_REG_LED_MAP, `FBC_RST_LED_MAP);
        rdchk("unmapped", 8'h02, 16'h0000);
        rdchk("cmd read", `FBC_REG_CMD, 16'h0000);
        $display("test regs done");
    endtask
    task t_io;
        tick(1);
        ext_in <= 6'h05;
        look(3);
        chk("red lamps", led_red_r, 16'h0005);
        wr(`FBC_REG_POL, 16'h003F);
        look(3);
        chk("red inverted", led_red_r, 16'h003A);
        tick(1);
        prot_in <= 4'h1;
        look(3);
        chk("signal 1", sig_out_r, 16'h0001);
        tick(1);
        prot_in <= 4'h0;
        ext_in <= 6'h00;
        look(3);
        chk("signal idle", sig_out_r, 16'h0000);
        wr(`FBC_REG_POL, 16'h0000);
        $display("test io done");
    endtask
    task t_cmd;
        logic [15:0] d;
        wr(`FBC_REG_IRQ_MASK, 16'h001F);
        rd(`FBC_REG_IRQ_STAT, d);
        run(1, 0, 2'h0, 6'h00, 3);
        chk("open pulse held button", no, 16'd8);
        run(0, 0, 2'h1, 6'h00, 1);
        chk("open pulse bus", no, 16'd8);
        look(1);
        chk("irq level", irq, 16'h0001);
        rdchk("irq stat", `FBC_REG_IRQ_STAT, 16'h0005);
        chk("irq cleared", irq, 16'h0000);
        $display("test cmd done");
    endtask
    task t_ilk;
        wr(`FBC_REG_ILK_CM, 16'h0001);
        run(0, 1, 2'h0, 6'h00, 1);
        chk("close refused", nc, 16'd0);
        wr(`FBC_REG_CTRL, 16'h0008);
        run(0, 1, 2'h0, 6'h00, 1);
        chk("preset refused", nc, 16'd0);
        tick(1);
        pos23 <= 2'h3;
        run(0, 1, 2'h0, 6'h00, 1);
        chk("preset close", nc, 16'd8);
        chk("lamp matrix", led_mtx_r, 16'h0023);
        rdchk("irq stat", `FBC_REG_IRQ_STAT, 16'h0006);
        $display("test interlock done");
    endtask
    task t_trip;
        wr(`FBC_REG_CTRL, 16'h0000);
        wr(`FBC_REG_ILK_CM, 16'h0000);
        wr(`FBC_REG_ILK_OM, 16'h0002);
        tick(1);
        prot_in <= 4'h2;
        look(3);
        chk("trip open", open_out_r, 16'h0001);
        rdchk("irq stat", `FBC_REG_IRQ_STAT, 16'h0008);
        tick(1);
        prot_in <= 4'h0;
        wr(`FBC_REG_CTRL, 16'h0010);
        tick(1);
        ext_in <= 6'h10;
        prot_in <= 4'h2;
        look(3);
        chk("trip blocked", open_out_r, 16'h0000);
        tick(1);
        ext_in <= 6'h00;
        prot_in <= 4'h0;
        $display("test trip done");
    endtask
    task t_cond;
        wr(`FBC_REG_CTRL, 16'h0000);
        wr(`FBC_REG_ILK_OM, 16'h0000);
        wr(`FBC_REG_OPEN_ASG, 16'h0001);
        run(0, 0, 2'h0, 6'h01, 1);
        chk("channel pulse", no, 16'd8);
        tick(1);
        ext_in <= 6'h00;
        wr(`FBC_REG_CTRL, 16'h0001);
        run(0, 0, 2'h0, 6'h01, 1);
        run(0, 0, 2'h0, 6'h01, 1);
        chk("level output", no, 16'd14);
        tick(1);
        ext_in <= 6'h00;
        look(3);
        chk("level released", open_out_r, 16'h0000);
        $display("test conditional done");
    endtask
    task t_meas;
        wr(`FBC_REG_CTRL, 16'h0002);
        wr(`FBC_REG_ENERGY_LO, 16'h0000);
        repeat (3) begin
            tick(2);
            ext_in <= 6'h08;
            tick(2);
            ext_in <= 6'h00;
        end
        rdchk("energy count", `FBC_REG_ENERGY_LO, 16'h0003);
        rdchk("power", `FBC_REG_P_MW, 16'h0180);
        rdchk("reactive", `FBC_REG_Q_MVAR, 16'hFF00);
        wr(`FBC_REG_SCALE_P, 16'h0200);
        rdchk("power scaled", `FBC_REG_P_MW, 16'h0300);
        $display("test measure done");
    endtask
    // ======================================
    // verdict, watchdog and main sequence
    task finish_test;
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 5000) begin
            err_total++;
            finish_test;
        end
    end
    initial begin
        tick(5);
        sys_rst <= 0;
        t_regs;
        t_io;
        t_cmd;
        t_ilk;
        t_trip;
        t_cond;
        t_meas;
        finish_test;
    end
endmodule // fbc_top_tb
